// ===== logic/dcr_cfg.svh
// Overview of operation
// - global enable register, one bit per channel
// - flag is read-only, ipend gated by enable
// - channel blocks at 0x100, 0x120, 0x140, 0x160
// - eight channel registers decoded from 0x00 to 0x1C
// - count-to-zero sets pending when bit 31 set
// - active falling sets pending when bit 30 set
// - burst bytes equal field value plus one
// - destination increments unless transmitting to peripheral
// - destination width 1/2/4, narrower if FIFO short
// - source increments unless receiving from peripheral
// - source width 1/2/4, narrower if count short
// - timeout prescale off, or clock over 2^8/16/24
// - every field resets to zero
// - on zero count reload, else disable channel
// - pending cleared by writing one to cause
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

// global register offsets
`define DCR_OFF_IRQ_ENABLE 12'h000
`define DCR_OFF_IRQ_FLAGS 12'h004
`define DCR_OFF_CHAN_BASE 12'h100
`define DCR_CHAN_SHIFT 5
`define DCR_CHAN_STRIDE 12'h020

// offsets inside one channel block
`define DCR_OFF_CTRL 5'h00
`define DCR_OFF_STATE 5'h04
`define DCR_OFF_SRC 5'h08
`define DCR_OFF_DST 5'h0C
`define DCR_OFF_CNT 5'h10
`define DCR_OFF_SRC_RLD 5'h14
`define DCR_OFF_DST_RLD 5'h18
`define DCR_OFF_CNT_RLD 5'h1C

// control field positions
`define DCR_CTRL_COUNT_ZERO_IRQ_ENABLE 31
`define DCR_CTRL_DISABLE_IRQ_ENABLE 30
`define DCR_CTRL_BURST_LSB 24
`define DCR_CTRL_DSTINC 22
`define DCR_CTRL_DSTWD_LSB 20
`define DCR_CTRL_SRCINC 18
`define DCR_CTRL_SRCWD_LSB 16
`define DCR_CTRL_TOPRE_LSB 14
`define DCR_CTRL_TOPER_LSB 11
`define DCR_CTRL_TOWAIT 10
`define DCR_CTRL_RLDEN 1
`define DCR_CTRL_EN 0
`define DCR_CTRL_WMASK 32'hDF77FFFF

// state register field positions
`define DCR_ST_TO_IF 6
`define DCR_ST_BUS_ERR 4
`define DCR_ST_RLD_IF 3
`define DCR_ST_CTZ_IF 2
`define DCR_ST_IPEND 1
`define DCR_ST_ACTIVE 0

// reset values
`define DCR_RST_WORD 32'h00000000
`define DCR_RST_PRESC 24'h000000
`define DCR_RST_TO 10'h000

// timeout timing
`define DCR_TICK1_BITS 8
`define DCR_TICK2_BITS 16
`define DCR_TO_BASE 10'h004

`endif

// ===== logic/dcr_dma_regs.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "dcr_cfg.svh"

module dcr_dma_regs #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dcr_pkg::dcr_bus_req_type bus_req,
  output logic [31:0] rd_data,
  input wire dcr_pkg::dcr_xfer_type [NCH-1:0] xfer,
  output dcr_pkg::dcr_chan_out_type [NCH-1:0] chan_out,
  output logic irq
);
  import dcr_pkg::*;

  // only four channel blocks exist in the map
  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("dcr_dma_regs: NCH must be 1 to 4");
  end

  typedef struct packed {
    logic [31:0] irq_en;
    logic [31:0] irq_flags;
    logic irq;
    logic [31:0] rdata;
    logic [23:0] presc;
    dcr_chan_type [NCH-1:0] ch;
    dcr_chan_out_type [NCH-1:0] out;
  } dcr_state_type;

  dcr_state_type s_q;
  dcr_state_type s_d;

  logic [11:0] ch_off;
  logic in_chan;
  logic [1:0] sel;
  logic [4:0] reg_off;
  logic aligned;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] pend_set;
  logic [NCH-1:0] clr_any;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] run;
  logic [NCH-1:0] tick;
  logic [31:0] clr_bits;

  // width code to byte count, reserved code moves one byte
  function automatic logic [2:0] width_bytes(input logic [1:0] code);
    logic [2:0] r;
    unique case (code)
      2'h0: r = 3'h1;
      2'h1: r = 3'h2;
      2'h2: r = 3'h4;
      2'h3: r = 3'h1;
    endcase
    return r;
  endfunction

  // channel block decode
  assign ch_off = bus_req.addr - `DCR_OFF_CHAN_BASE;
  assign in_chan = (bus_req.addr >= `DCR_OFF_CHAN_BASE) &&
                   (ch_off < 12'(NCH) * `DCR_CHAN_STRIDE);
  assign sel = ch_off[`DCR_CHAN_SHIFT+1:`DCR_CHAN_SHIFT];
  assign reg_off = ch_off[4:0];
  assign aligned = (bus_req.addr[1:0] == 2'h0);
  assign clr_bits = bus_req.wdata;

  // next state: bus writes first, then hardware events win
  always_comb begin
    s_d = s_q;
    s_d.presc = s_q.presc + 24'h000001;
    s_d.rdata = `DCR_RST_WORD;
    s_d.irq_flags = `DCR_RST_WORD;
    hit = '0;
    pend_set = '0;
    clr_any = '0;
    fall = '0;
    run = '0;
    tick = '0;

    // global enable register
    if (bus_req.wr && aligned && bus_req.addr == `DCR_OFF_IRQ_ENABLE) begin
      s_d.irq_en = bus_req.wdata;
    end

    for (int c = 0; c < NCH; c++) begin
      hit[c] = bus_req.wr && aligned && in_chan && (sel == 2'(c));

      // register writes
      if (hit[c]) begin
        unique case (reg_off)
          `DCR_OFF_CTRL: begin
            s_d.ch[c].ctrl = bus_req.wdata & `DCR_CTRL_WMASK;
            if (bus_req.wdata[`DCR_CTRL_EN] && !s_q.ch[c].active) begin
              s_d.ch[c].active = 1'b1;
              s_d.ch[c].to_cnt = `DCR_RST_TO;
              s_d.ch[c].to_armed = 1'b0;
            end
            if (!bus_req.wdata[`DCR_CTRL_EN] && s_q.ch[c].active) begin
              fall[c] = 1'b1;
            end
          end
          `DCR_OFF_STATE: begin
            // write one to clear each cause
            clr_any[c] = (clr_bits[`DCR_ST_TO_IF] && s_q.ch[c].to_if) ||
                         (clr_bits[`DCR_ST_BUS_ERR] && s_q.ch[c].bus_err) ||
                         (clr_bits[`DCR_ST_RLD_IF] && s_q.ch[c].rld_if) ||
                         (clr_bits[`DCR_ST_CTZ_IF] && s_q.ch[c].ctz_if);
            if (clr_bits[`DCR_ST_TO_IF]) s_d.ch[c].to_if = 1'b0;
            if (clr_bits[`DCR_ST_BUS_ERR]) s_d.ch[c].bus_err = 1'b0;
            if (clr_bits[`DCR_ST_RLD_IF]) s_d.ch[c].rld_if = 1'b0;
            if (clr_bits[`DCR_ST_CTZ_IF]) s_d.ch[c].ctz_if = 1'b0;
          end
          `DCR_OFF_SRC: s_d.ch[c].src = bus_req.wdata;
          `DCR_OFF_DST: s_d.ch[c].dst = bus_req.wdata;
          `DCR_OFF_CNT: s_d.ch[c].cnt = bus_req.wdata;
          `DCR_OFF_SRC_RLD: s_d.ch[c].src_rld = bus_req.wdata;
          `DCR_OFF_DST_RLD: s_d.ch[c].dst_rld = bus_req.wdata;
          `DCR_OFF_CNT_RLD: s_d.ch[c].cnt_rld = bus_req.wdata;
          default: begin
          end
        endcase
      end

      // transfer progress while active
      if (s_q.ch[c].active) begin
        if (xfer[c].rd_beat) begin
          if (s_q.ch[c].ctrl[`DCR_CTRL_SRCINC] && !xfer[c].from_periph) begin
            s_d.ch[c].src = s_d.ch[c].src + 32'(xfer[c].rd_bytes);
          end
          s_d.ch[c].cnt = s_d.ch[c].cnt - 32'(xfer[c].rd_bytes);
        end
        if (xfer[c].wr_beat && s_q.ch[c].ctrl[`DCR_CTRL_DSTINC] && !xfer[c].to_periph) begin
          s_d.ch[c].dst = s_d.ch[c].dst + 32'(xfer[c].wr_bytes);
        end
        // count-to-zero at burst end
        if (xfer[c].burst_end && s_d.ch[c].cnt == 32'h00000000) begin
          s_d.ch[c].ctz_if = 1'b1;
          if (s_q.ch[c].ctrl[`DCR_CTRL_COUNT_ZERO_IRQ_ENABLE]) pend_set[c] = 1'b1;
          if (s_q.ch[c].ctrl[`DCR_CTRL_RLDEN]) begin
            s_d.ch[c].src = s_q.ch[c].src_rld;
            s_d.ch[c].dst = s_q.ch[c].dst_rld;
            s_d.ch[c].cnt = s_q.ch[c].cnt_rld;
            s_d.ch[c].rld_if = 1'b1;
          end else begin
            fall[c] = 1'b1;
          end
        end
        if (xfer[c].bus_err) begin
          s_d.ch[c].bus_err = 1'b1;
          fall[c] = 1'b1;
        end
      end

      // timeout timer on the prescaled tick
      unique case (s_q.ch[c].ctrl[`DCR_CTRL_TOPRE_LSB+:2])
        2'h0: tick[c] = 1'b0;
        2'h1: tick[c] = &s_q.presc[`DCR_TICK1_BITS-1:0];
        2'h2: tick[c] = &s_q.presc[`DCR_TICK2_BITS-1:0];
        2'h3: tick[c] = &s_q.presc;
      endcase
      run[c] = s_q.ch[c].active && (s_q.ch[c].ctrl[`DCR_CTRL_TOPRE_LSB+:2] != 2'h0) &&
               (!s_q.ch[c].ctrl[`DCR_CTRL_TOWAIT] || s_q.ch[c].to_armed);
      if (s_q.ch[c].active && xfer[c].req) begin
        s_d.ch[c].to_armed = 1'b1;
        s_d.ch[c].to_cnt = `DCR_RST_TO;
      end else if (run[c] && tick[c]) begin
        if (s_q.ch[c].to_cnt == 10'((`DCR_TO_BASE << s_q.ch[c].ctrl[`DCR_CTRL_TOPER_LSB+:3]) - 10'h001)) begin
          s_d.ch[c].to_if = 1'b1;
          s_d.ch[c].to_cnt = `DCR_RST_TO;
          if (s_q.ch[c].ctrl[`DCR_CTRL_DISABLE_IRQ_ENABLE]) pend_set[c] = 1'b1;
        end else begin
          s_d.ch[c].to_cnt = s_q.ch[c].to_cnt + 10'h001;
        end
      end

      // channel disable: enable bit follows active
      if (fall[c]) begin
        s_d.ch[c].active = 1'b0;
        s_d.ch[c].ctrl[`DCR_CTRL_EN] = 1'b0;
        s_d.ch[c].to_cnt = `DCR_RST_TO;
        s_d.ch[c].to_armed = 1'b0;
        if (s_q.ch[c].ctrl[`DCR_CTRL_DISABLE_IRQ_ENABLE]) pend_set[c] = 1'b1;
      end

      // pending: set wins over clear
      s_d.ch[c].ipend = (s_q.ch[c].ipend && !clr_any[c]) || pend_set[c];
      s_d.irq_flags[c] = s_d.ch[c].ipend && s_d.irq_en[c];

      // settings for the engine
      s_d.out[c].active = s_d.ch[c].active;
      s_d.out[c].burst_bytes = {1'b0, s_d.ch[c].ctrl[`DCR_CTRL_BURST_LSB+:5]} + 6'h01;
      s_d.out[c].src_bytes = width_bytes(s_d.ch[c].ctrl[`DCR_CTRL_SRCWD_LSB+:2]);
      if (s_d.ch[c].cnt < 32'(s_d.out[c].src_bytes)) s_d.out[c].src_bytes = s_d.ch[c].cnt[2:0];
      s_d.out[c].dst_bytes = width_bytes(s_d.ch[c].ctrl[`DCR_CTRL_DSTWD_LSB+:2]);
      if (xfer[c].fifo_bytes < 6'(s_d.out[c].dst_bytes)) s_d.out[c].dst_bytes = xfer[c].fifo_bytes[2:0];
      s_d.out[c].src_addr = s_d.ch[c].src;
      s_d.out[c].dst_addr = s_d.ch[c].dst;
    end

    s_d.irq = |s_d.irq_flags;

    // read data, presented the cycle after the strobe
    if (bus_req.rd && aligned) begin
      if (bus_req.addr == `DCR_OFF_IRQ_ENABLE) begin
        s_d.rdata = s_q.irq_en;
      end else if (bus_req.addr == `DCR_OFF_IRQ_FLAGS) begin
        s_d.rdata = s_q.irq_flags;
      end else if (in_chan) begin
        for (int c = 0; c < NCH; c++) begin
          if (sel == 2'(c)) begin
            unique case (reg_off)
              `DCR_OFF_CTRL: s_d.rdata = s_q.ch[c].ctrl;
              `DCR_OFF_STATE: s_d.rdata = {25'h0000000, s_q.ch[c].to_if, 1'b0, s_q.ch[c].bus_err,
                                           s_q.ch[c].rld_if, s_q.ch[c].ctz_if, s_q.ch[c].ipend,
                                           s_q.ch[c].active};
              `DCR_OFF_SRC: s_d.rdata = s_q.ch[c].src;
              `DCR_OFF_DST: s_d.rdata = s_q.ch[c].dst;
              `DCR_OFF_CNT: s_d.rdata = s_q.ch[c].cnt;
              `DCR_OFF_SRC_RLD: s_d.rdata = s_q.ch[c].src_rld;
              `DCR_OFF_DST_RLD: s_d.rdata = s_q.ch[c].dst_rld;
              `DCR_OFF_CNT_RLD: s_d.rdata = s_q.ch[c].cnt_rld;
              default: s_d.rdata = `DCR_RST_WORD;
            endcase
          end
        end
      end
    end
  end

  // state register, all zero on reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rd_data = s_q.rdata;
  assign chan_out = s_q.out;
  assign irq = s_q.irq;

endmodule

// ===== logic/dcr_pkg.sv
package dcr_pkg;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dcr_bus_req_type;

  // per-channel events from the transfer engine
  typedef struct packed {
    logic rd_beat;
    logic [2:0] rd_bytes;
    logic wr_beat;
    logic [2:0] wr_bytes;
    logic burst_end;
    logic bus_err;
    logic req;
    logic to_periph;
    logic from_periph;
    logic [5:0] fifo_bytes;
  } dcr_xfer_type;

  // per-channel settings towards the transfer engine
  typedef struct packed {
    logic active;
    logic [5:0] burst_bytes;
    logic [2:0] src_bytes;
    logic [2:0] dst_bytes;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } dcr_chan_out_type;

  // per-channel register state
  typedef struct packed {
    logic [31:0] ctrl;
    logic to_if;
    logic bus_err;
    logic rld_if;
    logic ctz_if;
    logic ipend;
    logic active;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
    logic [31:0] src_rld;
    logic [31:0] dst_rld;
    logic [31:0] cnt_rld;
    logic [9:0] to_cnt;
    logic to_armed;
  } dcr_chan_type;

endpackage

// ===== tb/dcr_dma_regs_asserts.sv
`timescale 1ns/100ps
module dcr_dma_regs_asserts #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dcr_pkg::dcr_bus_req_type bus_req,
  input wire logic [31:0] rd_data,
  input wire dcr_pkg::dcr_xfer_type [NCH-1:0] xfer,
  input wire dcr_pkg::dcr_chan_out_type [NCH-1:0] chan_out,
  input wire logic irq
);
  import dcr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // register port answers
  read_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
    else $error("read data without read");
  unaligned_read_a: assert property (bus_req.rd && bus_req.addr[1:0] != 2'b00 |=> rd_data == 32'h0)
    else $error("unaligned read not zero");
  unmapped_read_a: assert property (bus_req.rd && (bus_req.addr inside {[12'h008:12'h0FF], [12'h180:12'hFFF]})
    |=> rd_data == 32'h0) else $error("unmapped read not zero");
  flag_irq_a: assert property (bus_req.rd && bus_req.addr == 12'h004 |=> (rd_data != 32'h0) == $past(irq))
    else $error("irq differs from flags");
  // channel settings and events
  burst_size_a: assert property (bus_req.wr && bus_req.addr == 12'h100
    |=> chan_out[0].burst_bytes == {1'b0, $past(bus_req.wdata[28:24])} + 6'h01) else $error("burst bytes wrong");
  bus_err_stop_a: assert property (chan_out[1].active && xfer[1].bus_err |=> !chan_out[1].active)
    else $error("bus error left channel active");
  src_hold_a: assert property (chan_out[1].active && xfer[1].from_periph && !xfer[1].burst_end && !bus_req.wr
    |=> $stable(chan_out[1].src_addr)) else $error("source moved on peripheral read");
  dst_hold_a: assert property (chan_out[1].active && xfer[1].to_periph && !xfer[1].burst_end && !bus_req.wr
    |=> $stable(chan_out[1].dst_addr)) else $error("destination moved on peripheral write");
  // main scenarios
  end_cov: cover property (chan_out[0].active && xfer[0].burst_end);
  err_cov: cover property (chan_out[1].active && xfer[1].bus_err);
  irq_cov: cover property ($rose(irq));
endmodule

bind dcr_dma_regs dcr_dma_regs_asserts #(.NCH(NCH)) u_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .bus_req(bus_req), .rd_data(rd_data), .xfer(xfer), .chan_out(chan_out), .irq(irq));

// ===== tb/dcr_xfer_model.sv
`timescale 1ns/100ps
module dcr_xfer_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dcr_pkg::dcr_chan_out_type [3:0] chan_out,
  input wire logic err,
  input wire logic periph,
  output dcr_pkg::dcr_xfer_type [3:0] xfer
);
  import dcr_pkg::*;
  logic [3:0][1:0] ph;
  // four-phase burst per active channel: read, two settle cycles, write with burst end
  // fifo count holds the last read, so the write width is settled before the write
  // a peripheral side never requests here, which lets the timeout run out
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      xfer <= '0;
      ph <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        xfer[c].rd_beat <= chan_out[c].active && (ph[c] == 2'h0);
        xfer[c].wr_beat <= (ph[c] == 2'h3);
        xfer[c].rd_bytes <= chan_out[c].src_bytes;
        xfer[c].wr_bytes <= chan_out[c].dst_bytes;
        if (xfer[c].rd_beat) begin
          xfer[c].fifo_bytes <= {3'b000, xfer[c].rd_bytes};
        end
        xfer[c].burst_end <= (ph[c] == 2'h3);
        xfer[c].req <= (ph[c] == 2'h3) && !periph;
        xfer[c].bus_err <= err;
        xfer[c].to_periph <= periph;
        xfer[c].from_periph <= periph;
        if (chan_out[c].active || ph[c] != 2'h0) begin
          ph[c] <= ph[c] + 2'h1;
        end
      end
    end
  end
endmodule

// ===== tb/tb_dcr_dma_regs.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t %h %h", $time, g, e); end end
module tb_dcr_dma_regs;
  import dcr_pkg::*;
  logic clk_sys;
  logic nrst;
  logic err;
  logic periph;
  dcr_bus_req_type bus_req;
  logic [31:0] rd_data;
  logic irq;
  dcr_xfer_type [3:0] xfer;
  dcr_chan_out_type [3:0] chan_out;
  int errors = 0;
  int checks = 0;

  dcr_dma_regs dut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data), .xfer(xfer),
    .chan_out(chan_out), .irq(irq));
  dcr_xfer_model engine (.clk_sys(clk_sys), .nrst(nrst), .chan_out(chan_out), .err(err), .periph(periph),
    .xfer(xfer));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] got;
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 got = rd_data;
    `CHK(got, e)
  endtask

  task automatic idle(input int c);
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 60 && chan_out[c].active !== 1'b0; i++) @(posedge clk_sys);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #100us;
    errors++;
    end_of_test();
  end

  // test sequence
  initial begin
    bus_req = '0;
    err = 1'b0;
    periph = 1'b0;
    nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    chk(12'h000, 32'h0);
    chk(12'h004, 32'h0);
    for (int o = 0; o < 32; o += 4) chk(12'h100 + 12'(o), 32'h0);
    for (int c = 0; c < 4; c++) for (int o = 8; o < 32; o += 4) wr(12'(256 + 32 * c + o), 32'(c * 256 + o));
    for (int c = 0; c < 4; c++) for (int o = 8; o < 32; o += 4) chk(12'(256 + 32 * c + o), 32'(c * 256 + o));
    chk(12'h10A, 32'h0);
    chk(12'h080, 32'h0);
    chk(12'h180, 32'h0);
    wr(12'h120, 32'hFFFFFFFE);
    chk(12'h120, 32'hDF77FFFE);
    wr(12'h000, 32'h0000000E);
    chk(12'h000, 32'h0000000E);
    // channel 0 runs to zero while its interrupt is masked
    wr(12'h108, 32'h1000);
    wr(12'h10C, 32'h2000);
    wr(12'h110, 32'h4);
    wr(12'h100, 32'h83660001);
    #1;
    `CHK(chan_out[0].burst_bytes, 6'h04)
    idle(0);
    chk(12'h104, 32'h6);
    chk(12'h108, 32'h1004);
    chk(12'h10C, 32'h2004);
    chk(12'h110, 32'h0);
    chk(12'h100, 32'h83660000);
    chk(12'h004, 32'h0);
    `CHK(irq, 1'b0)
    wr(12'h000, 32'h0000000F);
    chk(12'h004, 32'h1);
    `CHK(irq, 1'b1)
    wr(12'h104, 32'h4);
    chk(12'h104, 32'h0);
    `CHK(irq, 1'b0)
    // channel 1 reloads with a peripheral on both sides, then fails on the bus
    periph <= 1'b1;
    wr(12'h128, 32'h3000);
    wr(12'h134, 32'h3000);
    wr(12'h12C, 32'h4000);
    wr(12'h138, 32'h4000);
    wr(12'h130, 32'h2);
    wr(12'h13C, 32'h100);
    wr(12'h120, 32'h40450003);
    repeat (20) @(posedge clk_sys);
    #1;
    `CHK(chan_out[1].src_bytes, 3'h2)
    `CHK(chan_out[1].dst_bytes, 3'h1)
    chk(12'h128, 32'h3000);
    chk(12'h12C, 32'h4000);
    chk(12'h124, 32'hD);
    @(posedge clk_sys);
    err <= 1'b1;
    @(posedge clk_sys);
    err <= 1'b0;
    idle(1);
    chk(12'h124, 32'h1E);
    chk(12'h004, 32'h2);
    `CHK(irq, 1'b1)
    // channel 2 with a silent peripheral times out and stays active
    wr(12'h140, 32'h40004001);
    repeat (700) @(posedge clk_sys);
    chk(12'h144, 32'h1);
    repeat (400) @(posedge clk_sys);
    chk(12'h144, 32'h43);
    chk(12'h004, 32'h6);
    `CHK(irq, 1'b1)
    end_of_test();
  end
endmodule
